// ### logic/bst_dev.sv
// Memory-side end of the boundary-scan test port: controller, instruction
// register, bypass, identification and 109-cell boundary chain.
// Assumes the link pins are asynchronous to CLK and the test clock is much
// slower than CLK; the memory pins on RING_IN are asynchronous as well.
`timescale 1ns/1ps
`include "bst_defs.svh"

// Summary of operation
// - Read data undefined while external test active
// - Tester reapplies power-up after external test
// - Memory inputs held stable during chain capture
// - Clock recovery cycles needed after scan use
// - Cell 1 unused, 2 valid flag, 3-9 address
// - Chain holds 109 cells, last one internal
// - Tester keeps true/complement input clocks opposite
// - Echo clocks follow input clock except EXTEST/SAMPLE-Z
// - Five mode-select highs always reach reset state
// - Transitions use mode-select at test clock rise
// - Identification instruction loaded on reset entry
// - SAMPLE-Z floats outputs, captures inputs, shifts chain
// - Reserved codes unused; five defined codes decoded
module bst_dev
	import bst_pkg::*;
#(
	// Identification word; the value is arbitrary
	parameter logic [`BST_ID_W-1:0] ID_WORD = 32'h0A5A5001
)
(
	input wire logic CLK,
	input wire logic RST,
	bst_if.dev LINK,
	input wire logic [`BST_CHAIN_LEN:1] RING_IN,
	input wire logic X36_CFG,
	input wire logic MEM_K,
	output logic [`BST_CHAIN_LEN:1] RING_DRIVE,
	output logic EXTEST_ON,
	output logic OUT_HIZ,
	output logic READ_DATA_UNDEF,
	output logic CAPTURE_STB,
	output logic TAP_RESET,
	output logic ECHO_REF_TRUE,
	output logic ECHO_REF_INVERTED
);

	// Next controller state from the sampled mode-select level
	function automatic bst_state_type tap_next(input bst_state_type s, input logic m);
		case (s)
			ST_RESET: tap_next = m ? ST_RESET : ST_IDLE;
			ST_IDLE: tap_next = m ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: tap_next = m ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: tap_next = m ? ST_UPD_DR : ST_PAU_DR;
			ST_PAU_DR: tap_next = m ? ST_EX2_DR : ST_PAU_DR;
			ST_EX2_DR: tap_next = m ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: tap_next = m ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: tap_next = m ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: tap_next = m ? ST_UPD_IR : ST_PAU_IR;
			ST_PAU_IR: tap_next = m ? ST_EX2_IR : ST_PAU_IR;
			ST_EX2_IR: tap_next = m ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: tap_next = m ? ST_SEL_DR : ST_IDLE;
			default: tap_next = ST_RESET;
		endcase
	endfunction : tap_next

	// Data register chosen by an instruction; reserved codes fall to bypass
	function automatic bst_sel_type dr_select(input logic [`BST_IR_W-1:0] ir);
		case (ir)
			`BST_IR_EXTEST: dr_select = SEL_CHAIN;
			`BST_IR_SAMPLEZ: dr_select = SEL_CHAIN;
			`BST_IR_PRELOAD: dr_select = SEL_CHAIN;
			`BST_IR_IDCODE: dr_select = SEL_ID;
			default: dr_select = SEL_BYPASS;
		endcase
	endfunction : dr_select

	// Cell joined to a ball in the present width; open cells capture zero
	function automatic logic cell_live(input int idx, input logic wide);
		logic upper;
		upper = 1'b0;
		// Upper lanes come in pairs every four cells; the impedance_ref_pin cell (28)
		// and the loop_bypass_n cell (84) break the pattern, so each run restarts after them
		if ((idx >= 12 && idx <= 27 && ((idx - 12) % 4) < 2) ||
			(idx >= 29 && idx <= 46 && ((idx - 29) % 4) < 2) ||
			(idx >= 68 && idx <= 83 && ((idx - 68) % 4) < 2) ||
			(idx >= 85 && idx <= 102 && ((idx - 85) % 4) < 2))
		begin
			upper = 1'b1;
		end
		if (idx == 54 || idx == 58)
		begin
			upper = 1'b1;
		end
		if (idx == `BST_CELL_NC_FIRST || idx == `BST_CELL_NC_MID || idx == `BST_CELL_INTERNAL)
		begin
			cell_live = 1'b0;
		end
		else if (idx == `BST_CELL_ADDR_X18)
		begin
			cell_live = ~wide;
		end
		else
		begin
			cell_live = wide | ~upper;
		end
	endfunction : cell_live

	logic tck_s1_reg, tck_s2_reg, tck_s3_reg;
	logic tms_s1_reg, tms_s2_reg;
	logic tdi_s1_reg, tdi_s2_reg;
	logic k_s1_reg, k_s2_reg;
	logic [`BST_CHAIN_LEN:1] ring_s1_reg, ring_s2_reg;
	logic tck_rise, tck_fall;

	bst_state_type state_reg, state_next;
	logic [`BST_IR_W-1:0] ir_reg, ir_next;
	logic [`BST_IR_W-1:0] ir_sh_reg, ir_sh_next;
	logic [`BST_CHAIN_LEN:1] chain_reg, chain_next;
	logic [`BST_CHAIN_LEN:1] upd_reg, upd_next;
	logic [`BST_ID_W-1:0] id_reg, id_next;
	logic byp_reg, byp_next;
	logic tdo_reg, tdo_next;
	logic tdo_oe_reg, tdo_oe_next;
	logic cap_reg, cap_next;
	logic wide_reg, wide_next;
	logic echo_t_reg, echo_t_next;
	logic echo_i_reg, echo_i_next;
	bst_sel_type sel;
	logic [`BST_CHAIN_LEN:1] ring_live;

	// Synchronisers for every pin from outside the CLK domain
	always_ff @(posedge CLK)
	begin
		tck_s1_reg <= LINK.tck;
		tck_s2_reg <= tck_s1_reg;
		tck_s3_reg <= tck_s2_reg;
		tms_s1_reg <= LINK.tms;
		tms_s2_reg <= tms_s1_reg;
		tdi_s1_reg <= LINK.tdi;
		tdi_s2_reg <= tdi_s1_reg;
		k_s1_reg <= MEM_K;
		k_s2_reg <= k_s1_reg;
		ring_s1_reg <= RING_IN;
		ring_s2_reg <= ring_s1_reg;
	end

	// Edges of the test clock found from the settled samples only
	assign tck_rise = tck_s2_reg & ~tck_s3_reg;
	assign tck_fall = ~tck_s2_reg & tck_s3_reg;
	assign sel = dr_select(ir_reg);

	// Open cells are masked so an unused ball never shows pin noise
	always_comb
	begin
		for (int i = 1; i <= `BST_CHAIN_LEN; i++)
		begin
			ring_live[i] = ring_s2_reg[i] & cell_live(i, wide_reg);
		end
	end

	// Controller, shifters and update stage, stepping on test-clock edges
	always_comb
	begin
		state_next = state_reg;
		ir_next = ir_reg;
		ir_sh_next = ir_sh_reg;
		chain_next = chain_reg;
		upd_next = upd_reg;
		id_next = id_reg;
		byp_next = byp_reg;
		tdo_next = tdo_reg;
		tdo_oe_next = tdo_oe_reg;
		cap_next = 1'b0;
		wide_next = wide_reg;
		if (tck_rise)
		begin
			state_next = tap_next(state_reg, tms_s2_reg);
			case (state_reg)
				ST_CAP_IR: ir_sh_next = `BST_IR_CAPTURE;
				ST_SH_IR: ir_sh_next = {tdi_s2_reg, ir_sh_reg[`BST_IR_W-1:1]};
				ST_UPD_IR: ir_next = ir_sh_reg;
				ST_CAP_DR:
				begin
					id_next = ID_WORD;
					byp_next = 1'b0;
					if (sel == SEL_CHAIN)
					begin
						chain_next = ring_live;
						cap_next = 1'b1;
					end
				end
				ST_SH_DR:
				begin
					// Only the selected register moves; the others hold
					case (sel)
						SEL_CHAIN: chain_next = {tdi_s2_reg, chain_reg[`BST_CHAIN_LEN:2]};
						SEL_ID: id_next = {tdi_s2_reg, id_reg[`BST_ID_W-1:1]};
						default: byp_next = tdi_s2_reg;
					endcase
				end
				ST_UPD_DR:
				begin
					if (sel == SEL_CHAIN)
					begin
						upd_next = chain_reg;
					end
				end
				default:
				begin
				end
			endcase
			if (state_next == ST_RESET)
			begin
				ir_next = `BST_IR_IDCODE;
			end
		end
		// Data out changes on the falling edge so the tester samples it mid-bit
		if (tck_fall)
		begin
			tdo_oe_next = (state_reg == ST_SH_DR) || (state_reg == ST_SH_IR);
			if (state_reg == ST_SH_IR)
			begin
				tdo_next = ir_sh_reg[0];
			end
			else
			begin
				case (sel)
					SEL_CHAIN: tdo_next = chain_reg[1];
					SEL_ID: tdo_next = id_reg[0];
					default: tdo_next = byp_reg;
				endcase
			end
		end
		// Echo clocks track the input clock except under EXTEST (taken from the chain) and SAMPLE-Z (held low)
		case (ir_reg)
			`BST_IR_EXTEST:
			begin
				echo_t_next = upd_reg[`BST_CELL_ECHO_TRUE];
				echo_i_next = upd_reg[`BST_CELL_ECHO_INV];
			end
			`BST_IR_SAMPLEZ:
			begin
				echo_t_next = 1'b0;
				echo_i_next = 1'b0;
			end
			default:
			begin
				echo_t_next = k_s2_reg;
				echo_i_next = ~k_s2_reg;
			end
		endcase
	end

	// Registers; the width strap is caught while reset is held
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			state_reg <= ST_RESET;
			ir_reg <= `BST_IR_IDCODE;
			ir_sh_reg <= `BST_IR_CAPTURE;
			chain_reg <= '0;
			upd_reg <= '0;
			id_reg <= '0;
			byp_reg <= 1'b0;
			tdo_reg <= 1'b0;
			tdo_oe_reg <= 1'b0;
			cap_reg <= 1'b0;
			wide_reg <= X36_CFG;
			echo_t_reg <= 1'b0;
			echo_i_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			ir_reg <= ir_next;
			ir_sh_reg <= ir_sh_next;
			chain_reg <= chain_next;
			upd_reg <= upd_next;
			id_reg <= id_next;
			byp_reg <= byp_next;
			tdo_reg <= tdo_next;
			tdo_oe_reg <= tdo_oe_next;
			cap_reg <= cap_next;
			wide_reg <= wide_next;
			echo_t_reg <= echo_t_next;
			echo_i_reg <= echo_i_next;
		end
	end

	// Mode outputs; the core must stay in power-up state after external test
	assign EXTEST_ON = (ir_reg == `BST_IR_EXTEST);
	assign READ_DATA_UNDEF = (ir_reg == `BST_IR_EXTEST);
	assign OUT_HIZ = (ir_reg == `BST_IR_SAMPLEZ);
	assign TAP_RESET = (state_reg == ST_RESET);
	assign CAPTURE_STB = cap_reg;
	assign RING_DRIVE = upd_reg;
	assign ECHO_REF_TRUE = echo_t_reg;
	assign ECHO_REF_INVERTED = echo_i_reg;
	assign LINK.tdo = tdo_reg;
	assign LINK.tdo_oe = tdo_oe_reg;

endmodule : bst_dev

// ### logic/bst_defs.svh
// Shared constants of the boundary-scan test port: instruction codes,
// chain layout and link timing.
// Assumes inclusion by bare name from every file that needs them.
`ifndef BST_DEFS_SVH
`define BST_DEFS_SVH

// Instruction register and its codes; 3'h3, 3'h5, 3'h6 are reserved
`define BST_IR_W 3
`define BST_IR_EXTEST 3'h0
`define BST_IR_IDCODE 3'h1
`define BST_IR_SAMPLEZ 3'h2
`define BST_IR_PRELOAD 3'h4
`define BST_IR_BYPASS 3'h7
// Pattern loaded into the instruction shifter on Capture-IR
`define BST_IR_CAPTURE 3'h1

// Boundary chain layout, cells numbered from 1 next to the data output
`define BST_CHAIN_LEN 109
`define BST_ID_W 32
`define BST_CELL_NC_FIRST 1
`define BST_CELL_VALID 2
`define BST_CELL_ADDR_LO 3
`define BST_CELL_ADDR_HI 9
`define BST_CELL_ECHO_TRUE 47
`define BST_CELL_NC_MID 52
`define BST_CELL_ADDR_X18 64
`define BST_CELL_ECHO_INV 65
`define BST_CELL_INTERNAL 109

// Consecutive mode-select highs that always reach Test-Logic-Reset
`define BST_TLR_TMS_HIGH 5

// Link timing: the host end divides its own clock to make the test clock
`define BST_CLK_NS 10
`define BST_TCK_NS 160
`define BST_TCK_HALF ((`BST_TCK_NS / `BST_CLK_NS) / 2)
`define BST_DIV_W 4

// Host command port sizes and sequence lengths in test-clock steps
`define BST_LEN_W 8
`define BST_DATA_W 128
`define BST_HEAD_DR 3
`define BST_HEAD_IR 4
`define BST_TMS_HEAD_DR 4'h1
`define BST_TMS_HEAD_IR 4'h3
`define BST_TAIL_SCAN 2
`define BST_TAIL_RESET 1

`endif

// ### logic/bst_pkg.sv
// Types shared by both ends of the boundary-scan test port.
// Assumes nothing of its surroundings.
package bst_pkg;

	// Test controller states, Gray-coded along the usual walk
	typedef enum logic [3:0] {
		ST_RESET = 4'h0,
		ST_IDLE = 4'h1,
		ST_SEL_DR = 4'h3,
		ST_CAP_DR = 4'h2,
		ST_SH_DR = 4'h6,
		ST_EX1_DR = 4'h7,
		ST_UPD_DR = 4'h5,
		ST_PAU_DR = 4'h4,
		ST_EX2_DR = 4'hC,
		ST_SEL_IR = 4'hD,
		ST_CAP_IR = 4'hF,
		ST_SH_IR = 4'hE,
		ST_EX1_IR = 4'hA,
		ST_UPD_IR = 4'hB,
		ST_PAU_IR = 4'h9,
		ST_EX2_IR = 4'h8
	} bst_state_type;

	// Data register placed between the serial pins
	typedef enum logic [1:0] {
		SEL_CHAIN = 2'h0,
		SEL_ID = 2'h1,
		SEL_BYPASS = 2'h3
	} bst_sel_type;

	// Host commands
	typedef enum logic [1:0] {
		OP_RESET = 2'h0,
		OP_IR = 2'h1,
		OP_DR = 2'h3
	} bst_op_type;

	// Host sequencer phases
	typedef enum logic [2:0] {
		PH_IDLE = 3'h0,
		PH_HEAD = 3'h1,
		PH_SHIFT = 3'h3,
		PH_TAIL = 3'h2,
		PH_FIN = 3'h6
	} bst_phase_type;

endpackage : bst_pkg

// ### logic/bst_if.sv
// Serial test link between the tester end and the memory's test port.
// Assumes the tester drives clock, mode select and data in; the test port
// drives data out only while shifting, otherwise the line is pulled high.
`timescale 1ns/1ps

interface bst_if;
	logic tck;
	logic tms;
	logic tdi;
	logic tdo;
	logic tdo_oe;
	// Resolved data-out line; a board pull-up holds it high when undriven
	logic tdo_line;

	assign tdo_line = tdo_oe ? tdo : 1'b1;

	modport dev (input tck, input tms, input tdi, output tdo, output tdo_oe);
	modport host (output tck, output tms, output tdi, input tdo_line);
endinterface : bst_if

// ### logic/bst_host.sv
// Tester end of the boundary-scan link: makes the test clock by dividing
// CLK and walks the controller through reset, instruction and data scans.
// Assumes the first command after reset is a reset command.
`timescale 1ns/1ps
`include "bst_defs.svh"

module bst_host
	import bst_pkg::*;
(
	input wire logic CLK,
	input wire logic RST,
	bst_if.host LINK,
	input wire logic START,
	input wire logic [1:0] OP,
	input wire logic [`BST_LEN_W-1:0] LEN,
	input wire logic [`BST_DATA_W-1:0] DATA_IN,
	output logic BUSY,
	output logic DONE,
	output logic [`BST_DATA_W-1:0] DATA_OUT
);

	// Number of steps in a phase for a command
	function automatic logic [`BST_LEN_W-1:0] phase_len(input bst_phase_type ph,
		input bst_op_type op, input logic [`BST_LEN_W-1:0] len);
		case (ph)
			PH_HEAD: phase_len = (op == OP_RESET) ? `BST_LEN_W'(`BST_TLR_TMS_HIGH) :
				(op == OP_IR) ? `BST_LEN_W'(`BST_HEAD_IR) : `BST_LEN_W'(`BST_HEAD_DR);
			PH_SHIFT: phase_len = len;
			PH_TAIL: phase_len = (op == OP_RESET) ? `BST_LEN_W'(`BST_TAIL_RESET) :
				`BST_LEN_W'(`BST_TAIL_SCAN);
			default: phase_len = `BST_LEN_W'(1);
		endcase
	endfunction : phase_len

	bst_phase_type ph_reg, ph_next;
	bst_op_type op_reg, op_next;
	logic [`BST_LEN_W-1:0] len_reg, len_next;
	logic [`BST_LEN_W-1:0] step_reg, step_next;
	logic [`BST_DIV_W-1:0] div_reg, div_next;
	logic tck_reg, tck_next;
	logic tms_reg, tms_next;
	logic tdi_reg, tdi_next;
	logic done_reg, done_next;
	logic [`BST_DATA_W-1:0] din_reg, din_next;
	logic [`BST_DATA_W-1:0] dout_reg, dout_next;
	logic tdo_s1_reg, tdo_s2_reg;
	logic tick;
	logic last;
	logic [3:0] head_bits;

	// Data out comes from the far end, so it is synchronised first
	always_ff @(posedge CLK)
	begin
		tdo_s1_reg <= LINK.tdo_line;
		tdo_s2_reg <= tdo_s1_reg;
	end

	assign tick = (div_reg == `BST_DIV_W'(`BST_TCK_HALF - 1));
	assign last = (step_reg == phase_len(ph_reg, op_reg, len_reg) - `BST_LEN_W'(1));
	assign head_bits = (op_reg == OP_IR) ? `BST_TMS_HEAD_IR : `BST_TMS_HEAD_DR;

	// Sequencer: drive on falling test-clock edges, sample on rising ones
	always_comb
	begin
		ph_next = ph_reg;
		op_next = op_reg;
		len_next = len_reg;
		step_next = step_reg;
		div_next = div_reg;
		tck_next = tck_reg;
		tms_next = tms_reg;
		tdi_next = tdi_reg;
		done_next = 1'b0;
		din_next = din_reg;
		dout_next = dout_reg;
		if (ph_reg == PH_IDLE)
		begin
			div_next = '0;
			if (START)
			begin
				// A zero length is taken as one bit to keep the walk legal
				ph_next = PH_HEAD;
				op_next = bst_op_type'(OP);
				len_next = (LEN == '0) ? `BST_LEN_W'(1) : LEN;
				din_next = DATA_IN;
				dout_next = '0;
				step_next = '0;
				tms_next = 1'b1;
				tdi_next = 1'b0;
			end
		end
		else
		begin
			div_next = tick ? '0 : div_reg + `BST_DIV_W'(1);
			if (tick)
			begin
				tck_next = ~tck_reg;
				if (!tck_reg)
				begin
					// Rising edge: far end takes TMS/TDI, we take its data out
					if (ph_reg == PH_SHIFT)
					begin
						dout_next[step_reg[6:0]] = tdo_s2_reg;
					end
					step_next = last ? '0 : step_reg + `BST_LEN_W'(1);
					if (last)
					begin
						case (ph_reg)
							PH_HEAD: ph_next = (op_reg == OP_RESET) ? PH_TAIL : PH_SHIFT;
							PH_SHIFT: ph_next = PH_TAIL;
							PH_TAIL: ph_next = PH_FIN;
							default: ph_next = PH_IDLE;
						endcase
					end
				end
				else
				begin
					// Falling edge: present the bits of the step now current
					case (ph_reg)
						PH_HEAD: tms_next = (op_reg == OP_RESET) | head_bits[step_reg[1:0]];
						PH_SHIFT:
						begin
							tms_next = last;
							tdi_next = din_reg[step_reg[6:0]];
						end
						PH_TAIL: tms_next = (op_reg != OP_RESET) && (step_reg == '0);
						PH_FIN:
						begin
							tms_next = 1'b0;
							ph_next = PH_IDLE;
							done_next = 1'b1;
						end
						default: tms_next = 1'b0;
					endcase
				end
			end
		end
	end

	// Sequencer registers
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			ph_reg <= PH_IDLE;
			op_reg <= OP_RESET;
			len_reg <= '0;
			step_reg <= '0;
			div_reg <= '0;
			tck_reg <= 1'b0;
			tms_reg <= 1'b1;
			tdi_reg <= 1'b0;
			done_reg <= 1'b0;
			din_reg <= '0;
			dout_reg <= '0;
		end
		else
		begin
			ph_reg <= ph_next;
			op_reg <= op_next;
			len_reg <= len_next;
			step_reg <= step_next;
			div_reg <= div_next;
			tck_reg <= tck_next;
			tms_reg <= tms_next;
			tdi_reg <= tdi_next;
			done_reg <= done_next;
			din_reg <= din_next;
			dout_reg <= dout_next;
		end
	end

	assign LINK.tck = tck_reg;
	assign LINK.tms = tms_reg;
	assign LINK.tdi = tdi_reg;
	assign BUSY = (ph_reg != PH_IDLE);
	assign DONE = done_reg;
	assign DATA_OUT = dout_reg;

endmodule : bst_host

// ### verif/bst_assertions.sv
// Concurrent checks on the serial test link and the memory-side flags.
// Assumes one CLK domain, RST synchronous active high, link made by the tester end.
`timescale 1ns/1ps
`include "bst_defs.svh"

module bst_assertions (
	input wire logic CLK,
	input wire logic RST,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic tdo_oe,
	input wire logic TAP_RESET,
	input wire logic EXTEST_ON,
	input wire logic READ_DATA_UNDEF,
	input wire logic OUT_HIZ,
	input wire logic CAPTURE_STB,
	input wire logic MEM_K,
	input wire logic ECHO_REF_TRUE,
	input wire logic ECHO_REF_INVERTED,
	input wire logic [`BST_CHAIN_LEN:1] RING_DRIVE
);
	logic tck_q_reg;
	logic tck_rise;
	logic [2:0] hi_cnt_reg;
	logic [2:0] hi_cnt_next;

	// Count consecutive test-clock rises with mode select high; saturates to avoid wrap
	assign tck_rise = tck && !tck_q_reg;
	always_comb
	begin
		hi_cnt_next = hi_cnt_reg;
		if (tck_rise)
			hi_cnt_next = tms ? ((hi_cnt_reg == 3'h7) ? 3'h7 : hi_cnt_reg + 3'h1) : 3'h0;
	end
	always_ff @(posedge CLK)
	begin
		tck_q_reg <= RST ? 1'b0 : tck;
		hi_cnt_reg <= RST ? 3'h0 : hi_cnt_next;
	end

	// The dev end syncs the link, so a few CLK of lag are allowed in the reset-state and echo checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	property p_tlr_five;
		tck_rise && tms && hi_cnt_reg == 3'h4 |-> ##[1:8] TAP_RESET;
	endproperty
	a_tlr_five: assert property (p_tlr_five) else $error("no reset state after five highs");
	property p_tlr_leave;
		TAP_RESET && tck_rise && !tms |-> ##[1:8] !TAP_RESET;
	endproperty
	a_tlr_leave: assert property (p_tlr_leave) else $error("reset state not left");
	property p_tlr_stay;
		TAP_RESET && tck_rise && tms |=> TAP_RESET [*8];
	endproperty
	a_tlr_stay: assert property (p_tlr_stay) else $error("reset state left on high");
	property p_link_stable;
		tck_rise |-> $stable(tms) && $stable(tdi) ##1 $stable(tms) && $stable(tdi);
	endproperty
	a_link_stable: assert property (p_link_stable) else $error("link moved at clock rise");
	property p_instr_tlr;
		TAP_RESET [*2] |-> !EXTEST_ON && !OUT_HIZ && !tdo_oe;
	endproperty
	a_instr_tlr: assert property (p_instr_tlr) else $error("wrong instruction in reset");
	property p_cap_pulse;
		CAPTURE_STB |-> !tdo_oe && !TAP_RESET ##1 !CAPTURE_STB;
	endproperty
	a_cap_pulse: assert property (p_cap_pulse) else $error("bad capture strobe");
	property p_undef;
		EXTEST_ON |-> READ_DATA_UNDEF && !OUT_HIZ;
	endproperty
	a_undef: assert property (p_undef) else $error("read data not flagged");
	property p_echo_follow;
		(!EXTEST_ON && !OUT_HIZ && $stable(MEM_K)) [*6] |-> ECHO_REF_TRUE == MEM_K
			&& ECHO_REF_INVERTED == !MEM_K;
	endproperty
	a_echo_follow: assert property (p_echo_follow) else $error("echo not following");
	property p_echo_hiz;
		OUT_HIZ [*3] |-> !ECHO_REF_TRUE && !ECHO_REF_INVERTED;
	endproperty
	a_echo_hiz: assert property (p_echo_hiz) else $error("echo driven in float");
	property p_echo_extest;
		EXTEST_ON [*3] |-> ECHO_REF_TRUE == RING_DRIVE[47] && ECHO_REF_INVERTED == RING_DRIVE[65];
	endproperty
	a_echo_extest: assert property (p_echo_extest) else $error("echo not from chain");
endmodule : bst_assertions

// ### verif/testbench.sv
// Self-checking bench: tester end and memory end joined by the link.
// Assumes both ends reset together; the strap is caught only under reset.
`timescale 1ns/1ps
`include "bst_defs.svh"

module testbench import bst_pkg::*;;
	// Identification word; the value is arbitrary
	localparam logic [`BST_ID_W-1:0] ID_VAL = 32'h5C3A0E11;
	logic clk, rst, start, x36_cfg, mem_k, busy, done;
	logic extest_on, out_hiz, read_data_undef, capture_stb, tap_reset, echo_t, echo_i;
	logic [1:0] op;
	logic [7:0] len;
	logic [127:0] data_in, data_out, rnd;
	logic [109:1] ring_in, ring_drive;
	// Reserved codes must never be loaded by the tester, so only bypass is used
	logic [2:0] codes [4] = '{3'h7, 3'h7, 3'h7, 3'h7};
	int n_mismatch = 0;
	int checks_done = 0;
	int cycles = 0;

	bst_if link();
	bst_dev #(.ID_WORD(ID_VAL)) bst_dev_i (.CLK(clk), .RST(rst), .LINK(link), .RING_IN(ring_in),
		.X36_CFG(x36_cfg), .MEM_K(mem_k), .RING_DRIVE(ring_drive), .EXTEST_ON(extest_on),
		.OUT_HIZ(out_hiz), .READ_DATA_UNDEF(read_data_undef), .CAPTURE_STB(capture_stb),
		.TAP_RESET(tap_reset), .ECHO_REF_TRUE(echo_t), .ECHO_REF_INVERTED(echo_i));
	bst_host bst_host_i (.CLK(clk), .RST(rst), .LINK(link), .START(start), .OP(op), .LEN(len),
		.DATA_IN(data_in), .BUSY(busy), .DONE(done), .DATA_OUT(data_out));
	bst_assertions bst_assertions_i (.CLK(clk), .RST(rst), .tck(link.tck), .tms(link.tms),
		.tdi(link.tdi), .tdo_oe(link.tdo_oe), .TAP_RESET(tap_reset), .EXTEST_ON(extest_on),
		.READ_DATA_UNDEF(read_data_undef), .OUT_HIZ(out_hiz), .CAPTURE_STB(capture_stb),
		.MEM_K(mem_k), .ECHO_REF_TRUE(echo_t), .ECHO_REF_INVERTED(echo_i),
		.RING_DRIVE(ring_drive));

	// Clock, 10 ns period
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Memory input clock toggles slowly so the echoes can settle between edges
	always @(posedge clk)
	begin
		#1;
		if (cycles % 23 == 0)
			mem_k = ~mem_k;
	end

	// Hang guard, well above the expected run of some 13000 cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 80000)
		begin
			n_mismatch++;
			report_and_stop();
		end
	end

	task automatic check(input string what, input logic [127:0] seen, input logic [127:0] expv);
		checks_done++;
		if (seen !== expv)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, expv, seen);
		end
	endtask : check

	task report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop

	// One host command; START only while idle, then wait for the done pulse
	task automatic run(input bst_op_type o, input int n, input logic [127:0] d);
		int w;
		@(posedge clk);
		#1;
		start = 1'b1;
		op = o;
		len = n[7:0];
		data_in = d;
		@(posedge clk);
		#1;
		start = 1'b0;
		w = 0;
		while (done !== 1'b1 && w < 5000)
		begin
			@(posedge clk);
			#1;
			w++;
		end
		// A command that never finishes counts as a failure
		if (w >= 5000)
			n_mismatch++;
		check("busy_after_done", busy, 1'b0);
	endtask : run

	// Instruction load; the shifter always captures the fixed pattern first
	task automatic load_ir(input logic [2:0] code);
		run(OP_IR, 3, {125'h0, code});
		check("ir_capture", data_out[2:0], `BST_IR_CAPTURE);
	endtask : load_ir

	// Cells with no ball in the current width read back as 0
	function automatic logic open_cell(input int c, input logic x36);
		if (c == 1 || c == 52 || c == 109)
			return 1'b1;
		if (x36)
			return c == 64;
		return (c >= 12 && c <= 27 && (c - 12) % 4 < 2) || (c >= 29 && c <= 46 && (c - 29) % 4 < 2)
			|| c == 54 || c == 58 || (c >= 68 && c <= 83 && (c - 68) % 4 < 2)
			|| (c >= 85 && c <= 102 && (c - 85) % 4 < 2);
	endfunction : open_cell

	// Cell 1 leaves first, so cell c lands in output bit c-1
	function automatic logic [127:0] chain_exp(input logic [109:1] r, input logic x36);
		logic [127:0] e;
		e = 128'h0;
		for (int c = 1; c <= 109; c++)
			e[c-1] = open_cell(c, x36) ? 1'b0 : r[c];
		return e;
	endfunction : chain_exp

	initial
	begin
		rst = 1'b1;
		start = 1'b0;
		op = 2'h0;
		len = 8'h0;
		data_in = 128'h0;
		x36_cfg = 1'b1;
		mem_k = 1'b0;
		ring_in = '0;
		void'($urandom(32'h6FEC));
		for (int k = 1; k >= 0; k--)
		begin
			// A fresh reset also serves as the restart after external test
			x36_cfg = k[0];
			rst = 1'b1;
			repeat (4) @(posedge clk);
			#1;
			rst = 1'b0;
			@(posedge clk);
			#1;
			check("tap_reset", tap_reset, 1'b1);
			run(OP_RESET, 1, 128'h0);
			check("left_reset", tap_reset, 1'b0);
			run(OP_DR, 32, {$urandom, $urandom, $urandom, $urandom});
			check("id_word", data_out[31:0], ID_VAL);
			foreach (codes[i])
			begin
				load_ir(codes[i]);
				rnd = {$urandom, $urandom, $urandom, $urandom};
				run(OP_DR, 8, rnd);
				check("bypass", data_out[7:0], {rnd[6:0], 1'b0});
			end
			// Ring inputs held still across every capture
			rnd = {$urandom, $urandom, $urandom, $urandom};
			ring_in = rnd[108:0];
			load_ir(`BST_IR_SAMPLEZ);
			check("float", {extest_on, out_hiz}, 2'b01);
			run(OP_DR, 109, 128'h0);
			check("samplez", data_out, chain_exp(ring_in, x36_cfg));
			load_ir(`BST_IR_PRELOAD);
			rnd = {$urandom, $urandom, $urandom, $urandom};
			run(OP_DR, 109, rnd);
			check("sample", data_out, chain_exp(ring_in, x36_cfg));
			check("preload", ring_drive, rnd[108:0]);
			load_ir(`BST_IR_EXTEST);
			check("extest", {extest_on, read_data_undef, echo_t, echo_i},
				{2'b11, rnd[46], rnd[64]});
			run(OP_RESET, 1, 128'h0);
			check("reset_instr", {extest_on, out_hiz}, 2'b00);
		end
		report_and_stop();
	end
endmodule : testbench
